// ### common/pmdec_pkg.sv
/*
  pmdec_pkg: constants and carriers for the program-memory decoder.
  assumes an 8-bit processor core with a 16-bit program address.
*/
`default_nettype none
package pmdec_pkg;
  localparam int unsigned PMDEC_ADDR_W      = 16;
  localparam int unsigned PMDEC_DATA_W      = 8;
  localparam int unsigned PMDEC_FLASH_MIN   = 1024;
  localparam int unsigned PMDEC_FLASH_MAX   = 12288;
  localparam int unsigned PMDEC_FLASH_DEF   = 12288;
  localparam logic [15:0] PMDEC_OPT_FIRST   = 16'h0000;
  localparam logic [15:0] PMDEC_OPT_LAST    = 16'h0001;
  localparam logic [15:0] PMDEC_RST_FIRST   = 16'h0002;
  localparam logic [15:0] PMDEC_RST_LAST    = 16'h0003;
  localparam logic [15:0] PMDEC_VEC_FIRST   = 16'h0004;
  localparam logic [15:0] PMDEC_VEC_LAST    = 16'h003D;
  localparam logic [15:0] PMDEC_PROG_FIRST  = 16'h003E;
  localparam logic [7:0]  PMDEC_UNIMPL_BYTE = 8'hFF;
  localparam logic [7:0]  PMDEC_ZERO_BYTE   = 8'h00;

  typedef enum logic [2:0] {
    PMDEC_REG_OPTION,
    PMDEC_REG_RESET_VEC,
    PMDEC_REG_IRQ_VEC,
    PMDEC_REG_PROGRAM,
    PMDEC_REG_UNIMPL
  } pmdec_region_t;

  // one program-memory request from the core
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } pmdec_req_t;

  // the same, toward the flash array
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } pmdec_flash_t;
endpackage : pmdec_pkg
`default_nettype wire

// ### rtl/pmdec_decoder.sv
/*
  pmdec_decoder: program-memory decoder between processor core and flash.
  assumes the core and flash share clk_i; flash read data is valid one
  cycle after its read strobe; data-space cycles come from the same core.
*/
`timescale 1ns/1ps
`default_nettype none

// Operation
// - accept full 16-bit, 64 KB program addresses
// - flash size parameter, 1 KB-12 KB, bottom
// - reads beyond implemented flash return FF
// - writes beyond implemented flash are dropped
// - option, reset vector, vector table at bottom
// - program area from 003E to last byte
// - data-memory cycles select no storage
module pmdec_decoder
  import pmdec_pkg::*;
#(
  parameter int unsigned FLASH_BYTES = PMDEC_FLASH_DEF
) (
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          reset_n_i,
  // processor program-memory port
  input  wire pmdec_req_t    prog_req_i,
  output logic [7:0]         prog_rdata_o,
  output logic               prog_rvalid_o,
  // processor data-memory port
  input  wire logic          data_rd_i,
  input  wire logic          data_wr_i,
  input  wire logic [15:0]   data_addr_i,
  // flash array side
  output var pmdec_flash_t   flash_o,
  input  wire logic [7:0]    flash_rdata_i,
  // decode status
  output var pmdec_region_t  region_o,
  output logic               data_sel_o
);

  localparam logic [16:0] FLASH_END = 17'(FLASH_BYTES);
  localparam logic [15:0] PROG_LAST = 16'(FLASH_BYTES - 1);

  ////////////////////////////////////////////////////////////////////////
  // address decode
  logic          in_flash;
  pmdec_region_t next_region;

  // compare all 17 bits so 12 KB, not a power of two, does not wrap
  assign in_flash = {1'b0, prog_req_i.addr} < FLASH_END;

  always_comb begin
    next_region = PMDEC_REG_UNIMPL;
    if (!in_flash) begin
      next_region = PMDEC_REG_UNIMPL;
    end else if (prog_req_i.addr <= PMDEC_OPT_LAST) begin
      next_region = PMDEC_REG_OPTION;
    end else if (prog_req_i.addr <= PMDEC_RST_LAST) begin
      next_region = PMDEC_REG_RESET_VEC;
    end else if (prog_req_i.addr <= PMDEC_VEC_LAST) begin
      next_region = PMDEC_REG_IRQ_VEC;
    end else begin
      next_region = PMDEC_REG_PROGRAM;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // flash strobes are combinational so the array sees the request cycle
  always_comb begin
    flash_o.addr  = prog_req_i.addr;
    flash_o.wdata = prog_req_i.wdata;
    flash_o.rd    = prog_req_i.rd & in_flash;
    flash_o.wr    = prog_req_i.wr & in_flash;
  end

  // data space is not decoded: nothing is ever selected
  assign data_sel_o = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // read return
  logic          rd_pend;
  logic          rd_unimpl;
  logic          next_rd_pend;
  logic          next_rd_unimpl;
  logic          next_rvalid;
  logic [7:0]    next_rdata;
  pmdec_region_t region;

  // flash answers one cycle after its strobe and the output register adds
  // one more, so a return lands two edges after the request
  always_comb begin
    next_rd_pend   = prog_req_i.rd;
    next_rd_unimpl = prog_req_i.rd & ~in_flash;
    next_rvalid    = rd_pend;
    next_rdata     = prog_rdata_o;
    if (rd_pend) begin
      next_rdata = rd_unimpl ? PMDEC_UNIMPL_BYTE : flash_rdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_pend       <= 1'b0;
      rd_unimpl     <= 1'b0;
      prog_rvalid_o <= 1'b0;
      prog_rdata_o  <= PMDEC_ZERO_BYTE;
      region        <= PMDEC_REG_UNIMPL;
    end else begin
      rd_pend       <= next_rd_pend;
      rd_unimpl     <= next_rd_unimpl;
      prog_rvalid_o <= next_rvalid;
      prog_rdata_o  <= next_rdata;
      region        <= next_region;
    end
  end

  assign region_o = region;

  ////////////////////////////////////////////////////////////////////////
  // checks
  // an out-of-range size would leave part of the map undecoded
  initial begin
    a_size_range: assert (FLASH_BYTES >= PMDEC_FLASH_MIN && FLASH_BYTES <= PMDEC_FLASH_MAX)
      else $error("flash size out of range");
  end

  a_unimpl_ff: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    prog_req_i.rd && !in_flash |-> ##2 prog_rvalid_o && prog_rdata_o == PMDEC_UNIMPL_BYTE)
    else $error("unimplemented read did not return FF");

  a_impl_read: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    prog_req_i.rd && in_flash |=> ##1 prog_rdata_o == $past(flash_rdata_i))
    else $error("flash read data not returned");

  a_drop_write: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    prog_req_i.wr && {1'b0, prog_req_i.addr} >= FLASH_END |-> !flash_o.wr)
    else $error("write beyond flash reached the array");

  a_pass_write: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    prog_req_i.wr && prog_req_i.addr <= PROG_LAST |-> flash_o.wr)
    else $error("write inside flash was dropped");

  a_vec_region: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    prog_req_i.addr >= PMDEC_VEC_FIRST && prog_req_i.addr <= PMDEC_VEC_LAST
    |=> region == PMDEC_REG_IRQ_VEC)
    else $error("vector table misdecoded");

  a_rst_region: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    prog_req_i.addr >= PMDEC_RST_FIRST && prog_req_i.addr <= PMDEC_RST_LAST
    |=> region == PMDEC_REG_RESET_VEC)
    else $error("reset vector misdecoded");

  a_prog_region: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    prog_req_i.addr >= PMDEC_PROG_FIRST && prog_req_i.addr <= PROG_LAST
    |=> region == PMDEC_REG_PROGRAM)
    else $error("program area misdecoded");

  a_no_alias: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    prog_req_i.addr > PROG_LAST |-> !flash_o.rd ##1 region == PMDEC_REG_UNIMPL)
    else $error("address above flash aliased");

  a_no_data: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    data_rd_i || data_wr_i |-> !data_sel_o && !flash_o.rd && !flash_o.wr
    || prog_req_i.rd || prog_req_i.wr)
    else $error("data cycle selected storage");

  a_opt_region: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    prog_req_i.addr <= PMDEC_OPT_LAST |=> region == PMDEC_REG_OPTION)
    else $error("option bytes misdecoded");

  a_rd_pass: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    prog_req_i.rd && prog_req_i.addr <= PROG_LAST |-> flash_o.rd)
    else $error("read inside flash was dropped");

  a_rd_block: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    prog_req_i.rd && {1'b0, prog_req_i.addr} >= FLASH_END |-> !flash_o.rd)
    else $error("read beyond flash reached the array");

  // the array must never see a strobe that the core did not issue
  a_no_stray_rd: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !prog_req_i.rd |-> !flash_o.rd)
    else $error("flash read without a core read");

  a_no_stray_wr: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !prog_req_i.wr |-> !flash_o.wr)
    else $error("flash write without a core write");

  // address and data reach the array untouched, all sixteen address bits
  a_addr_pass: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    flash_o.rd || flash_o.wr |-> flash_o.addr == prog_req_i.addr
    && flash_o.wdata == prog_req_i.wdata)
    else $error("flash address or data differs from the core request");

  a_rvalid_rd: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !prog_req_i.rd |-> ##2 !prog_rvalid_o)
    else $error("read return without a read");

  a_wr_no_ret: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    prog_req_i.wr && !prog_req_i.rd |-> ##2 !prog_rvalid_o)
    else $error("write produced a read return");

  // read data stands between returns, so a late sample still sees it
  a_rdata_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !prog_rvalid_o |-> $stable(prog_rdata_o))
    else $error("read data changed without a return");

  ////////////////////////////////////////////////////////////////////////
  // covers of the main scenarios
  c_unimpl_rd: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    prog_req_i.rd && !in_flash);
  c_impl_rd: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    prog_req_i.rd && in_flash ##1 prog_req_i.rd);
  c_drop_wr: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    prog_req_i.wr && !in_flash);
  c_opt_wr: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    prog_req_i.wr && prog_req_i.addr <= PMDEC_OPT_LAST);
  // data-space cycles are watched only to show that they pass untouched
  c_data_cyc: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    (data_rd_i || data_wr_i) && {1'b0, data_addr_i} < FLASH_END);

endmodule : pmdec_decoder
`default_nettype wire

// ### verification/pmdec_flash_model.sv
/*
  pmdec_flash_model: flash array behind the program-memory decoder.
  assumes the decoder gates strobes to in-range addresses.
*/
`timescale 1ns/1ps
`default_nettype none
module pmdec_flash_model
  import pmdec_pkg::*;
#(
  parameter int unsigned FLASH_BYTES = 4096
) (
  // clock
  input  wire logic         clk_i,
  // decoder side
  input  wire pmdec_flash_t flash_i,
  output logic [7:0]        rdata_o
);
  logic [7:0] mem [FLASH_BYTES];
  always @(posedge clk_i) begin
    if (flash_i.wr) mem[flash_i.addr] <= flash_i.wdata;
    // data is good for one cycle only, then flips so stale use shows up
    rdata_o <= flash_i.rd ? mem[flash_i.addr] : ~rdata_o;
  end
endmodule : pmdec_flash_model
`default_nettype wire

// ### verification/pmdec_decoder_tb.sv
/*
  pmdec_decoder_tb: self-checking bench for the program-memory decoder.
  assumes a 4 KB variant and the flash model on the far side.
*/
`timescale 1ns/1ps
`default_nettype none
module pmdec_decoder_tb;
  import pmdec_pkg::*;
  localparam int unsigned FB = 4096;
  logic clk_i = 1'b0, reset_n_i = 1'b0, drd = 1'b0, dwr = 1'b0;
  logic [15:0] dad = 16'h0000;
  pmdec_req_t req = '0;
  logic [7:0] rdata, frd;
  logic rvalid, dsel;
  pmdec_flash_t fl;
  pmdec_region_t region;
  localparam int unsigned FB_BIG = PMDEC_FLASH_MAX;
  logic [7:0] rdata_big, frd_big;
  logic rvalid_big, dsel_big;
  pmdec_flash_t fl_big;
  pmdec_region_t region_big;
  int bad_count = 0, tests_run = 0;
  always #2 clk_i = ~clk_i;
  pmdec_decoder #(.FLASH_BYTES(FB)) dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .prog_req_i(req), .prog_rdata_o(rdata), .prog_rvalid_o(rvalid),
    .data_rd_i(drd), .data_wr_i(dwr), .data_addr_i(dad), .flash_o(fl),
    .flash_rdata_i(frd), .region_o(region), .data_sel_o(dsel));
  pmdec_flash_model #(.FLASH_BYTES(FB)) flash (.clk_i(clk_i), .flash_i(fl), .rdata_o(frd));
  // second variant at 12 KB, fed from the same core request
  pmdec_decoder #(.FLASH_BYTES(FB_BIG)) dut_big (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .prog_req_i(req), .prog_rdata_o(rdata_big), .prog_rvalid_o(rvalid_big),
    .data_rd_i(drd), .data_wr_i(dwr), .data_addr_i(dad), .flash_o(fl_big),
    .flash_rdata_i(frd_big), .region_o(region_big), .data_sel_o(dsel_big));
  pmdec_flash_model #(.FLASH_BYTES(FB_BIG)) flash_big (.clk_i(clk_i), .flash_i(fl_big),
    .rdata_o(frd_big));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  function automatic pmdec_region_t reg_of(input logic [15:0] a);
    if (a <= PMDEC_OPT_LAST) return PMDEC_REG_OPTION;
    if (a <= PMDEC_RST_LAST) return PMDEC_REG_RESET_VEC;
    if (a <= PMDEC_VEC_LAST) return PMDEC_REG_IRQ_VEC;
    if (a < FB) return PMDEC_REG_PROGRAM;
    return PMDEC_REG_UNIMPL;
  endfunction : reg_of
  // one byte access; a read expects d back two edges later
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    logic in_r;
    in_r = (a < FB);
    @(posedge clk_i) req <= '{rd: !w, wr: w, addr: a, wdata: d};
    #1 chk({6'h00, fl.rd, fl.wr}, {6'h00, !w & in_r, w & in_r});
    @(posedge clk_i) req <= '0;
    #1 chk({5'h00, region}, {5'h00, reg_of(a)});
    @(posedge clk_i);
    #1 chk({7'h00, rvalid}, {7'h00, !w});
    if (!w) chk(rdata, d);
  endtask : acc
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_map;
    logic [15:0] a [5] = '{16'h0000, 16'h0002, 16'h003D, 16'h003E, 16'h0FFF};
    foreach (a[i]) acc(1'b1, a[i], 8'hA0 + 8'(i));
    foreach (a[i]) acc(1'b0, a[i], 8'hA0 + 8'(i));
    $display("t_map done");
  endtask : t_map
  task automatic t_beyond;
    acc(1'b1, 16'h1000, 8'h11);
    acc(1'b1, 16'hF000, 8'h22);
    acc(1'b0, 16'h1000, PMDEC_UNIMPL_BYTE);
    acc(1'b0, 16'hFFFF, PMDEC_UNIMPL_BYTE);
    acc(1'b0, 16'h0000, 8'hA0);
    $display("t_beyond done");
  endtask : t_beyond
  task automatic t_data;
    @(posedge clk_i) begin
      drd <= 1'b1;
      dwr <= 1'b1;
      dad <= 16'h003E;
    end
    #1 chk({4'h0, dsel_big, fl_big.wr, dsel, fl.wr}, 8'h00);
    @(posedge clk_i) drd <= 1'b0;
    dwr <= 1'b0;
    acc(1'b0, 16'h003E, 8'hA3);
    $display("t_data done");
  endtask : t_data
  // reset in mid-run clears the read return and the region
  task automatic t_reset;
    acc(1'b0, 16'h0002, 8'hA1);
    @(posedge clk_i) reset_n_i <= 1'b0;
    #1 chk({rvalid, 4'h0, region}, {1'b0, 4'h0, PMDEC_REG_UNIMPL});
    chk(rdata, PMDEC_ZERO_BYTE);
    @(posedge clk_i) reset_n_i <= 1'b1;
    acc(1'b0, 16'h003D, 8'hA2);
    $display("t_reset done");
  endtask : t_reset
  // 12 KB is not a power of two: the edge at 2FFF/3000 needs a full compare
  task automatic t_big;
    @(posedge clk_i) req <= '{rd: 1'b0, wr: 1'b1, addr: 16'h2FFF, wdata: 8'h5C};
    #1 chk({7'h00, fl_big.wr}, 8'h01);
    @(posedge clk_i) req <= '{rd: 1'b1, wr: 1'b0, addr: 16'h3000, wdata: 8'h00};
    #1 chk({6'h00, fl_big.rd, fl_big.wr}, 8'h00);
    @(posedge clk_i) req <= '{rd: 1'b1, wr: 1'b0, addr: 16'h2FFF, wdata: 8'h00};
    #1 chk({7'h00, fl_big.rd}, 8'h01);
    chk({5'h00, region_big}, {5'h00, PMDEC_REG_UNIMPL});
    @(posedge clk_i) req <= '0;
    #1 chk({rvalid_big, 7'h00}, 8'h80);
    chk(rdata_big, PMDEC_UNIMPL_BYTE);
    @(posedge clk_i);
    #1 chk({rvalid_big, 7'h00}, 8'h80);
    chk(rdata_big, 8'h5C);
    $display("t_big done");
  endtask : t_big
  task automatic finish_test;
    $display("compares %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  initial begin
    repeat (4) @(posedge clk_i);
    reset_n_i <= 1'b1;
    t_map();
    t_beyond();
    t_data();
    t_reset();
    t_big();
    finish_test();
  end
  initial begin
    #4000;
    bad_count++;
    finish_test();
  end
endmodule : pmdec_decoder_tb
`default_nettype wire
